//--- adc_seq_pkg.sv
// constants, types and decode helpers for the converter sequencer
// assumes a single 100 MHz clock that also stands in for the oscillator
`default_nettype none
package adc_seq_pkg;

    // ==========================================
    // register map
    localparam logic [2:0] OFF_CTRL_A = 3'h0;
    localparam logic [2:0] OFF_CTRL_B = 3'h1;
    localparam logic [2:0] OFF_RES_HI = 3'h2;
    localparam logic [2:0] OFF_RES_LO = 3'h3;
    localparam logic [2:0] OFF_FLAG = 3'h4;
    localparam logic [2:0] OFF_IRQ_EN = 3'h5;

    localparam int BIT_ON = 0;
    localparam int BIT_GO = 1;
    localparam int CHAN_LSB = 2;
    localparam int CLKSEL_LSB = 4;

    localparam logic [9:0] RESULT_RESET = 10'h000;

    // ==========================================
    // timing
    localparam logic [1:0] INSTR_LAST = 2'h3;
    localparam logic [3:0] CONV_TAD_LAST = 4'ha;
    localparam logic [3:0] ABORT_TAD_LAST = 4'h1;
    localparam logic [3:0] RC_DIV_LAST = 4'hf;
    localparam int NUM_CHAN = 21;
    localparam int NUM_INTERNAL = 13;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RC_DELAY,
        ST_CONVERT,
        ST_ABORT_WAIT
    } seq_state_e;

    // ==========================================
    // clock select decode
    function automatic logic is_rc_clock(input logic [2:0] sel);
        return sel[1:0] == 2'h3;
    endfunction

    // last count of the oscillator divider, zero where no divider applies
    function automatic logic [6:0] div_last(input logic [2:0] sel);
        case (sel)
            3'h1: return 7'h07;
            3'h5: return 7'h0f;
            3'h2: return 7'h1f;
            3'h6: return 7'h3f;
            default: return 7'h00;
        endcase
    endfunction

endpackage
`default_nettype wire

//--- conv_clock_gen.sv
// conversion bit-period tick generator
// assumes run is held for the whole conversion and its abort wait
`timescale 1ns/10ps
`default_nettype none
module conv_clock_gen
    import adc_seq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic [2:0] clk_sel,
    output logic tad_tick
);

    typedef struct packed {
        logic [6:0] cnt;
        logic [3:0] rc_cnt;
        logic tick;
    } gen_s;

    gen_s r_reg, r_next;

    // ==========================================
    // dividers
    always_comb begin
        r_next = r_reg;
        // rc divider runs free so its rate ignores the system select
        r_next.rc_cnt = r_reg.rc_cnt + 4'h1;
        r_next.tick = 1'b0;
        if (!run) begin
            r_next.cnt = 7'h00;
        end else if (is_rc_clock(clk_sel)) begin
            r_next.tick = r_reg.rc_cnt == RC_DIV_LAST;
        end else if (div_last(clk_sel) != 7'h00) begin
            // reserved selects never tick, so a conversion on them stalls
            if (r_reg.cnt == div_last(clk_sel)) begin
                r_next.cnt = 7'h00;
                r_next.tick = 1'b1;
            end else begin
                r_next.cnt = r_reg.cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tad_tick = r_reg.tick;

endmodule // conv_clock_gen
`default_nettype wire

//--- channel_decode.sv
// channel code to one-hot analog mux select
// assumes the caller registers the result before it leaves the block
`timescale 1ns/10ps
`default_nettype none
module channel_decode
    import adc_seq_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0
)
(
    input wire logic [4:0] code,
    output logic [NUM_CHAN-1:0] sel
);

    // ==========================================
    // decode
    always_comb begin
        sel = '0;
        for (int i = 0; i < NUM_INTERNAL; i++) begin
            if (code == 5'(i)) begin
                sel[i] = 1'b1;
            end
        end
        for (int j = 0; j < 8; j++) begin
            // the two top pins are not bonded out on the small package
            if (code == 5'(16 + j) && !(SMALL_PACKAGE && j >= 6)) begin
                sel[NUM_INTERNAL + j] = 1'b1;
            end
        end
        // codes 13-15 and 24 up match nothing above: no source
    end

endmodule // channel_decode
`default_nettype wire

//--- adc_conversion_sequencer.sv
// sequencer for a ten-bit successive approximation converter
// assumes a same-clock register port and core sleep level, and an
// asynchronous comparator output from the analog block
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer
    import adc_seq_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic sleep_active,
    input wire logic cmp_in,
    output logic analog_power_on,
    output logic sample_hold_en,
    output logic [9:0] sar_trial,
    output logic [NUM_CHAN-1:0] chan_sel,
    output logic conv_done_flag,
    output logic wake_req
);

    typedef struct packed {
        seq_state_e state;
        logic converter_on;
        logic [4:0] channel_select;
        logic [2:0] conv_clock_select;
        logic conv_done_flag;
        logic conv_done_irq_enable;
        logic [9:0] result;
        logic [9:0] trial;
        logic [3:0] tad_cnt;
        logic [1:0] instr_cnt;
        logic sleep_off;
        logic wake;
        logic hold_en;
        logic power;
        logic [NUM_CHAN-1:0] mux;
        logic [7:0] rdata;
        logic cmp_meta;
        logic cmp_sync;
    } seq_s;

    seq_s r_reg, r_next;

    logic tad_tick;
    logic tick_run;
    logic [NUM_CHAN-1:0] mux_dec;

    // ==========================================
    // helpers
    conv_clock_gen i_conv_clock_gen (
        .mclk(mclk),
        .rst(rst),
        .run(tick_run),
        .clk_sel(r_reg.conv_clock_select),
        .tad_tick(tad_tick)
    );

    channel_decode #(
        .SMALL_PACKAGE(SMALL_PACKAGE)
    ) i_channel_decode (
        .code(r_reg.channel_select),
        .sel(mux_dec)
    );

    assign tick_run = (r_reg.state == ST_CONVERT) || (r_reg.state == ST_ABORT_WAIT);

    // ==========================================
    // next state
    logic wr_a;
    logic go_wr;
    logic on_wr;
    logic busy;
    logic abort;
    logic [3:0] bit_idx;

    always_comb begin
        r_next = r_reg;
        r_next.wake = 1'b0;
        r_next.rdata = 8'h00;
        r_next.cmp_meta = cmp_in;
        r_next.cmp_sync = r_reg.cmp_meta;
        wr_a = wr_en && (addr == OFF_CTRL_A);
        go_wr = wr_data[BIT_GO];
        on_wr = wr_data[BIT_ON];
        busy = (r_reg.state == ST_RC_DELAY) || (r_reg.state == ST_CONVERT);
        abort = 1'b0;
        bit_idx = CONV_TAD_LAST - r_reg.tad_cnt;

        // ---- register reads, data one cycle later
        if (rd_en) begin
            case (addr)
                OFF_CTRL_A: begin
                    r_next.rdata = {1'b0, r_reg.channel_select, busy,
                                    r_reg.converter_on};
                end
                OFF_CTRL_B: begin
                    r_next.rdata = {1'b0, r_reg.conv_clock_select, 4'h0};
                end
                OFF_RES_HI: begin
                    r_next.rdata = {6'h00, r_reg.result[9:8]};
                end
                OFF_RES_LO: begin
                    r_next.rdata = r_reg.result[7:0];
                end
                OFF_FLAG: begin
                    r_next.rdata = {7'h00, r_reg.conv_done_flag};
                end
                OFF_IRQ_EN: begin
                    r_next.rdata = {7'h00, r_reg.conv_done_irq_enable};
                end
                default: begin
                    r_next.rdata = 8'h00;
                end
            endcase
        end

        // ---- register writes
        if (wr_a) begin
            r_next.converter_on = on_wr;
            r_next.channel_select = wr_data[CHAN_LSB +: 5];
        end
        if (wr_en && addr == OFF_CTRL_B) begin
            r_next.conv_clock_select = wr_data[CLKSEL_LSB +: 3];
        end
        if (wr_en && addr == OFF_FLAG) begin
            r_next.conv_done_flag = wr_data[0];
        end
        if (wr_en && addr == OFF_IRQ_EN) begin
            r_next.conv_done_irq_enable = wr_data[0];
        end

        // ---- abort causes while busy
        if (busy) begin
            if (wr_a && (!go_wr || !on_wr)) begin
                abort = 1'b1;
            end
            if (sleep_active && !is_rc_clock(r_reg.conv_clock_select)) begin
                abort = 1'b1;
                r_next.sleep_off = 1'b1;
            end
        end

        // ---- sequencer
        case (r_reg.state)
            ST_IDLE: begin
                // the on bit must already be set before this write; a go in
                // the same write that powers up is ignored
                if (wr_a && go_wr && on_wr && r_reg.converter_on) begin
                    r_next.tad_cnt = 4'h0;
                    r_next.instr_cnt = 2'h0;
                    r_next.trial = 10'h000;
                    if (is_rc_clock(r_reg.conv_clock_select)) begin
                        r_next.state = ST_RC_DELAY;
                    end else begin
                        r_next.state = ST_CONVERT;
                    end
                end
            end
            ST_RC_DELAY: begin
                if (abort) begin
                    r_next.state = ST_ABORT_WAIT;
                    r_next.tad_cnt = 4'h0;
                end else if (r_reg.instr_cnt == INSTR_LAST) begin
                    r_next.state = ST_CONVERT;
                end else begin
                    r_next.instr_cnt = r_reg.instr_cnt + 2'h1;
                end
            end
            ST_CONVERT: begin
                if (abort) begin
                    // partial trial is dropped, result stays as it was
                    r_next.state = ST_ABORT_WAIT;
                    r_next.tad_cnt = 4'h0;
                    r_next.trial = 10'h000;
                end else if (tad_tick) begin
                    if (r_reg.tad_cnt == 4'h0) begin
                        // first period takes the hold, then trial bit 9
                        r_next.trial = 10'h200;
                    end else begin
                        r_next.trial[bit_idx] = r_reg.cmp_sync;
                        if (bit_idx != 4'h0) begin
                            r_next.trial[bit_idx - 4'h1] = 1'b1;
                        end
                    end
                    if (r_reg.tad_cnt == CONV_TAD_LAST) begin
                        r_next.state = ST_IDLE;
                        r_next.result = {r_reg.trial[9:1], r_reg.cmp_sync};
                        r_next.conv_done_flag = 1'b1;
                        r_next.trial = 10'h000;
                        if (sleep_active) begin
                            if (r_reg.conv_done_irq_enable) begin
                                r_next.wake = 1'b1;
                            end else begin
                                r_next.sleep_off = 1'b1;
                            end
                        end
                    end else begin
                        r_next.tad_cnt = r_reg.tad_cnt + 4'h1;
                    end
                end
            end
            ST_ABORT_WAIT: begin
                if (tad_tick) begin
                    if (r_reg.tad_cnt == ABORT_TAD_LAST) begin
                        r_next.state = ST_IDLE;
                    end else begin
                        r_next.tad_cnt = r_reg.tad_cnt + 4'h1;
                    end
                end
            end
            default: begin
                r_next.state = ST_IDLE;
            end
        endcase

        // power-down from sleep lasts only while the core sleeps
        if (!sleep_active) begin
            r_next.sleep_off = 1'b0;
        end
        // converter off also ends any busy phase; checked after the case
        if (!r_next.converter_on) begin
            r_next.state = ST_IDLE;
            r_next.trial = 10'h000;
        end

        // ---- analog controls, registered
        r_next.power = r_next.converter_on && !r_next.sleep_off;
        // acquiring whenever powered and idle, so tracking resumes after abort
        r_next.hold_en = r_next.power && (r_next.state == ST_IDLE);
        r_next.mux = r_next.power ? mux_dec : '0;
    end

    // ==========================================
    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.state <= ST_IDLE;
            r_reg.result <= RESULT_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================
    // outputs
    assign rd_data = r_reg.rdata;
    assign analog_power_on = r_reg.power;
    assign sample_hold_en = r_reg.hold_en;
    assign sar_trial = r_reg.trial;
    assign chan_sel = r_reg.mux;
    assign conv_done_flag = r_reg.conv_done_flag;
    assign wake_req = r_reg.wake;

endmodule // adc_conversion_sequencer
`default_nettype wire

//--- adc_seq_monitor.sv
// port assertions for the converter sequencer
// assumes it is bound onto adc_conversion_sequencer, one clock domain
`timescale 1ns/10ps
`default_nettype none
module adc_seq_monitor
    import adc_seq_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic sleep_active,
    input wire logic cmp_in,
    input wire logic analog_power_on,
    input wire logic sample_hold_en,
    input wire logic [9:0] sar_trial,
    input wire logic [NUM_CHAN-1:0] chan_sel,
    input wire logic conv_done_flag,
    input wire logic wake_req
);
    // ========
    // properties
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence rd_of(logic [2:0] a);
        rd_en && addr == a;
    endsequence
    sequence power_off_wr;
        wr_en && addr == OFF_CTRL_A && !wr_data[BIT_ON];
    endsequence
    a_flag_sticky: assert property (
        $fell(conv_done_flag) |-> $past(wr_en && addr == OFF_FLAG && !wr_data[0]))
        else $error("done flag dropped without a clearing write");
    a_off_power: assert property (
        power_off_wr |-> ##[1:2] !analog_power_on)
        else $error("converter still powered after switch off");
    a_chan_onehot: assert property ($onehot0(chan_sel))
        else $error("more than one channel selected");
    a_wake_flag: assert property (wake_req |-> ##[0:1] conv_done_flag)
        else $error("wake request without done flag");
    a_wake_pulse: assert property (wake_req |=> !wake_req)
        else $error("wake request longer than one cycle");
    a_ctrl_a_top: assert property (
        rd_of(OFF_CTRL_A) |=> rd_data[7] == 1'b0)
        else $error("control a bit 7 not zero");
    a_ctrl_b_spare: assert property (
        rd_of(OFF_CTRL_B) |=> rd_data[7] == 1'b0 && rd_data[3:0] == 4'h0)
        else $error("control b spare bits not zero");
    a_res_hi_top: assert property (
        rd_of(OFF_RES_HI) |=> rd_data[7:2] == 6'h00)
        else $error("result high upper bits not zero");
endmodule // adc_seq_monitor

bind adc_conversion_sequencer adc_seq_monitor #(.SMALL_PACKAGE(SMALL_PACKAGE)) i_adc_seq_monitor (
    .mclk(mclk),
    .rst(rst),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .sleep_active(sleep_active),
    .cmp_in(cmp_in),
    .analog_power_on(analog_power_on),
    .sample_hold_en(sample_hold_en),
    .sar_trial(sar_trial),
    .chan_sel(chan_sel),
    .conv_done_flag(conv_done_flag),
    .wake_req(wake_req)
);
`default_nettype wire

//--- adc_conversion_sequencer_test.sv
// self-checking bench for the converter sequencer
// assumes the package and the bound port monitor are compiled first
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer_test import adc_seq_pkg::*;;
    logic mclk = 0, rst = 1, wr_en = 0, rd_en = 0, sleep_active = 0, cmp_in = 0;
    logic [2:0] addr = 0;
    logic [7:0] wr_data = 0, rd_data;
    logic analog_power_on, sample_hold_en, conv_done_flag, wake_req, rd_dly = 0;
    logic [9:0] sar_trial, v = 0, old;
    logic [NUM_CHAN-1:0] chan_sel;
    logic [10:0] exp_q[$], e;
    logic [2:0] sels [6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int fail_count = 0, tests_run = 0, cyc = 0, wakes = 0, n;

    adc_conversion_sequencer i_adc_conversion_sequencer (.mclk(mclk), .rst(rst),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .sleep_active(sleep_active), .cmp_in(cmp_in), .analog_power_on(analog_power_on),
        .sample_hold_en(sample_hold_en), .sar_trial(sar_trial), .chan_sel(chan_sel),
        .conv_done_flag(conv_done_flag), .wake_req(wake_req));

    always #5 mclk = ~mclk;

    // ========
    // bus tasks and checks
    task automatic chk(input string nm, input logic [20:0] s, input logic [20:0] x);
        tests_run++;
        if (s !== x) begin
            fail_count++;
            $display("[FAIL] %s exp %h seen %h", nm, x, s);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] x);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back({a, x});
        @(posedge mclk);
        rd_en <= 1'b0;
    endtask
    task automatic go(input logic [2:0] sel, input logic [4:0] ch);
        wr(OFF_CTRL_B, {1'b0, sel, 4'h0});
        wr(OFF_CTRL_A, {1'b0, ch, 2'b01}); // power up before go
        repeat (20) @(posedge mclk); // acquisition wait
        v <= 10'($urandom);
        wr(OFF_CTRL_A, {1'b0, ch, 2'b11});
    endtask
    task automatic wait_flag();
        n = 0;
        while (conv_done_flag !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    function automatic logic [20:0] sel_of(input logic [4:0] c);
        if (c < 5'd13) return 21'h1 << c;
        if (c >= 5'd16 && c < 5'd24) return 21'h1 << (c - 5'd3);
        return 21'h0;
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ========
    // comparator model, read monitor, timeout
    always @(posedge mclk) begin
        cmp_in <= (v >= sar_trial);
        rd_dly <= rd_en;
        if (rd_dly) begin
            e = exp_q.pop_front();
            chk($sformatf("reg %0d", e[10:8]), {13'h0, rd_data}, {13'h0, e[7:0]});
        end
        if (wake_req === 1'b1)
            wakes++;
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            summarize();
        end
    end

    // ========
    // scenarios
    initial begin
        void'($urandom(47575));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++)
            rd(3'(a), 8'h00);
        wr(OFF_CTRL_B, 8'hff);
        rd(OFF_CTRL_B, 8'h70);
        wr(OFF_CTRL_A, 8'hfe);
        rd(OFF_CTRL_A, 8'h7c);
        wr(OFF_CTRL_A, 8'h03);
        rd(OFF_CTRL_A, 8'h01);
        rd(OFF_RES_LO, 8'h00);
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00);
        for (int c = 0; c < 32; c++) begin
            wr(OFF_CTRL_A, {1'b0, 5'(c), 2'b01});
            repeat (2) @(posedge mclk);
            chk("chan_sel", chan_sel, sel_of(5'(c)));
        end
        foreach (sels[i]) begin
            go(sels[i], 5'(i));
            wait_flag();
            if (sels[i][1:0] == 2'h3)
                chk("rc time", 21'(n >= 164 && n <= 186), 21'h1);
            else
                chk("tads", 21'(n / (8 << (2 * sels[i][1] + sels[i][2]))), 21'd11);
            rd(OFF_RES_HI, {6'h00, v[9:8]});
            rd(OFF_RES_LO, v[7:0]);
            rd(OFF_CTRL_A, {1'b0, 5'(i), 2'b01});
            rd(OFF_FLAG, 8'h01);
            wr(OFF_FLAG, 8'h00);
            rd(OFF_FLAG, 8'h00);
        end
        // abort mid-conversion keeps the old result
        old = v;
        go(3'h1, 5'h01);
        rd(OFF_CTRL_A, 8'h07);
        repeat (30) @(posedge mclk);
        wr(OFF_CTRL_A, 8'h05);
        n = 0;
        while (sample_hold_en !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        chk("abort wait", 21'(n >= 8 && n <= 24), 21'h1);
        chk("sar idle", {11'h000, sar_trial}, 21'h0);
        rd(OFF_RES_HI, {6'h00, old[9:8]});
        rd(OFF_RES_LO, old[7:0]);
        rd(OFF_FLAG, 8'h00);
        // reserved clock select never ticks: conversion stalls until switched off
        go(3'h0, 5'h03);
        repeat (100) @(posedge mclk);
        rd(OFF_CTRL_A, 8'h0f);
        wr(OFF_CTRL_A, 8'h0c);
        rd(OFF_CTRL_A, 8'h0c);
        chk("power", 21'(analog_power_on), 21'h0);
        rd(OFF_FLAG, 8'h00);
        // finish during sleep, wake enabled then disabled
        wr(OFF_IRQ_EN, 8'h01);
        for (int k = 0; k < 2; k++) begin
            go(3'h3, 5'h00);
            sleep_active <= 1'b1;
            wait_flag();
            repeat (3) @(posedge mclk);
            chk("wakes", 21'(wakes), 21'h1);
            if (k == 1)
                chk("power", 21'(analog_power_on), 21'h0);
            rd(OFF_CTRL_A, 8'h01);
            sleep_active <= 1'b0;
            wr(OFF_FLAG, 8'h00);
            wr(OFF_IRQ_EN, 8'h00);
        end
        // sleep on a divided clock aborts
        go(3'h1, 5'h00);
        repeat (20) @(posedge mclk);
        sleep_active <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("power", 21'(analog_power_on), 21'h0);
        rd(OFF_CTRL_A, 8'h01);
        rd(OFF_FLAG, 8'h00);
        sleep_active <= 1'b0;
        // reset in mid-conversion
        go(3'h1, 5'h02);
        repeat (20) @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        chk("power", 21'(analog_power_on), 21'h0);
        rd(OFF_CTRL_A, 8'h00);
        rd(OFF_CTRL_B, 8'h00);
        rd(OFF_RES_LO, 8'h00);
        repeat (4) @(posedge mclk);
        summarize();
    end
endmodule // adc_conversion_sequencer_test
`default_nettype wire
